// ---- hdl/biss_position_slave.sv ----
// serial position link slave: request, busy, frame, crc and timeout
`timescale 1ns/1ps
`default_nettype none
module biss_position_slave #(
   parameter int INIT_CYC = biss_slave_pkg::INIT_CYC
) (
   input  wire logic                               CLK_SYS,
   input  wire logic                               RESETN,
   input  wire logic                               MA,
   output var  logic                               SLO,
   input  wire logic                               POS_VALID,
   output var  logic                               POS_READY,
   input  wire logic [biss_slave_pkg::ST_W-1:0]    POS_ST,
   input  wire logic [biss_slave_pkg::MT_W-1:0]    POS_MT,
   input  wire logic [biss_slave_pkg::ERR_N-1:0]   ERR_SRC,
   input  wire logic [biss_slave_pkg::WARN_N-1:0]  WARN_SRC,
   input  wire logic [biss_slave_pkg::CLR_N-1:0]   CLEAR_CMD,
   output var  logic [biss_slave_pkg::CLR_N-1:0]   CLEAR_PULSE,
   output var  logic [biss_slave_pkg::ERR_N-1:0]   ERR_STATUS,
   output var  logic [biss_slave_pkg::WARN_N-1:0]  WARN_STATUS,
   output var  logic                               INIT_DONE
);
   localparam int FB  = biss_slave_pkg::FRAME_BITS;
   localparam int CW  = biss_slave_pkg::CNT_W;
   localparam int PW  = biss_slave_pkg::POS_W;
   localparam int IW  = $clog2(INIT_CYC + 1);
   localparam logic [IW-1:0] INIT_LAST = IW'(INIT_CYC - 1);
   localparam logic [CW-1:0] BUSY_C    = CW'(biss_slave_pkg::BUSY_CYC);
   localparam logic [1:0]    BUSY_E    = 2'(biss_slave_pkg::BUSY_EDGES);
   localparam logic [biss_slave_pkg::BCNT_W-1:0] FB_C =
      biss_slave_pkg::BCNT_W'(FB);

   biss_slave_pkg::link_state_t st_q;
   logic          ma_s1_q;
   logic          ma_s2_q;
   logic          ma_s3_q;
   logic          ma_rise;
   logic          ma_fall;
   logic [CW-1:0] per_cnt_q;
   logic [CW-1:0] period_q;
   logic [CW:0]   tout_lim;
   logic          tout_hit;
   logic [CW-1:0] busy_cnt_q;
   logic [CW+1:0] busy_need;
   logic [1:0]    rcnt_q;
   logic [biss_slave_pkg::BCNT_W-1:0] bcnt_q;
   logic [FB-1:0] shift_q;
   logic [FB-1:0] frame;
   logic [PW-1:0] pos_q;
   logic [PW-1:0] fifo_data;
   logic [PW-1:0] sample;
   logic          fifo_valid;
   logic          req;
   logic          start_ok;
   logic [IW-1:0] init_cnt_q;
   logic [biss_slave_pkg::CLR_N-1:0] cmd_prev_q;
   logic          cmd_new;
   logic [biss_slave_pkg::DATA_W-1:0] dword;

   // two-flop synchroniser, third flop only for edge detection
   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
      begin
         ma_s1_q <= 1'b1;
         ma_s2_q <= 1'b1;
         ma_s3_q <= 1'b1;
      end
      else
      begin
         ma_s1_q <= MA;
         ma_s2_q <= ma_s1_q;
         ma_s3_q <= ma_s2_q;
      end
   end
   assign ma_rise = ma_s2_q && !ma_s3_q;
   assign ma_fall = !ma_s2_q && ma_s3_q;

   // clock period measured between rising edges
   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
      begin
         per_cnt_q <= '0;
         period_q  <= '0;
      end
      else if (ma_rise)
      begin
         per_cnt_q <= '0;
         period_q  <= per_cnt_q + 1'b1;
      end
      else if (per_cnt_q != biss_slave_pkg::CNT_MAX)
         per_cnt_q <= per_cnt_q + 1'b1;
   end
   assign tout_lim = {1'b0, period_q} + (CW+1)'(period_q >> 1);
   assign tout_hit = ma_s2_q && ({1'b0, per_cnt_q} >= tout_lim);

   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
         init_cnt_q <= '0;
      else if (!INIT_DONE)
         init_cnt_q <= init_cnt_q + 1'b1;
   end
   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
         INIT_DONE <= 1'b0;
      else if (init_cnt_q == INIT_LAST)
         INIT_DONE <= 1'b1;
   end

   // clear command: one pulse per fresh write, single bit only
   assign cmd_new = $onehot(CLEAR_CMD) && (cmd_prev_q == '0);
   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
      begin
         cmd_prev_q  <= '0;
         CLEAR_PULSE <= '0;
      end
      else
      begin
         cmd_prev_q  <= CLEAR_CMD;
         CLEAR_PULSE <= cmd_new ? CLEAR_CMD : '0;
      end
   end

   // sticky status, a new event wins over a clear
   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
      begin
         ERR_STATUS  <= '0;
         WARN_STATUS <= '0;
      end
      else
      begin
         ERR_STATUS  <= (CLEAR_PULSE[biss_slave_pkg::CLR_ERR] ? '0 :
                         ERR_STATUS) | ERR_SRC;
         WARN_STATUS <= (CLEAR_PULSE[biss_slave_pkg::CLR_WARN] ? '0 :
                         WARN_STATUS) | WARN_SRC;
      end
   end

   sample_buffer #(
      .WIDTH (PW),
      .DEPTH (biss_slave_pkg::FIFO_DEPTH)
   ) u_buf (
      .clk       (CLK_SYS),
      .rst_n     (RESETN),
      .in_valid  (POS_VALID),
      .in_ready  (POS_READY),
      .in_data   ({POS_MT, POS_ST}),
      .out_valid (fifo_valid),
      .out_ready (req),
      .out_data  (fifo_data)
   );

   assign req    = (st_q == biss_slave_pkg::ST_IDLE) && INIT_DONE && ma_fall;
   assign sample = fifo_valid ? fifo_data : pos_q;
   assign dword  = {sample, ~|ERR_STATUS, ~|WARN_STATUS};
   assign frame  = {2'b10, dword, ~biss_slave_pkg::crc6(dword)};

   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
         pos_q <= '0;
      else if (req)
         pos_q <= sample;
   end

   assign busy_need = (CW+2)'({period_q, 1'b0}) + (CW+2)'(BUSY_C);
   assign start_ok  = (rcnt_q == BUSY_E) &&
                      ((CW+2)'(busy_cnt_q) >= busy_need);

   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
      begin
         st_q       <= biss_slave_pkg::ST_IDLE;
         SLO        <= 1'b1;
         shift_q    <= '0;
         bcnt_q     <= '0;
         busy_cnt_q <= '0;
         rcnt_q     <= '0;
      end
      else
      begin
         case (st_q)
            biss_slave_pkg::ST_IDLE:
            begin
               SLO <= 1'b1;
               if (req)
               begin
                  st_q       <= biss_slave_pkg::ST_BUSY;
                  SLO        <= 1'b0;
                  shift_q    <= frame;
                  busy_cnt_q <= '0;
                  rcnt_q     <= '0;
               end
            end
            biss_slave_pkg::ST_BUSY:
            begin
               if (busy_cnt_q != biss_slave_pkg::CNT_MAX)
                  busy_cnt_q <= busy_cnt_q + 1'b1;
               if (ma_rise && rcnt_q != BUSY_E)
                  rcnt_q <= rcnt_q + 1'b1;
               if (ma_rise && start_ok)
               begin
                  st_q    <= biss_slave_pkg::ST_DATA;
                  SLO     <= shift_q[FB-1];
                  shift_q <= {shift_q[FB-2:0], 1'b0};
                  bcnt_q  <= 6'h01;
               end
            end
            biss_slave_pkg::ST_DATA:
            begin
               if (tout_hit)
               begin
                  st_q <= biss_slave_pkg::ST_IDLE;
                  SLO  <= 1'b1;
               end
               else if (ma_rise && bcnt_q == FB_C)
               begin
                  st_q <= biss_slave_pkg::ST_TOUT;
                  SLO  <= 1'b0;
               end
               else if (ma_rise)
               begin
                  SLO     <= shift_q[FB-1];
                  shift_q <= {shift_q[FB-2:0], 1'b0};
                  bcnt_q  <= bcnt_q + 1'b1;
               end
            end
            biss_slave_pkg::ST_TOUT:
            begin
               if (tout_hit)
               begin
                  st_q <= biss_slave_pkg::ST_IDLE;
                  SLO  <= 1'b1;
               end
            end
            default:
            begin
               st_q <= biss_slave_pkg::ST_IDLE;
               SLO  <= 1'b1;
            end
         endcase
      end
   end

   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RESETN);

   sequence request_s;
      req;
   endsequence
   sequence ack_s;
      !SLO && st_q == biss_slave_pkg::ST_BUSY;
   endsequence

   request_ack_a: assert property (request_s |=> ack_s)
      else $error("no busy acknowledge after request");
   busy_time_a: assert property (
      st_q == biss_slave_pkg::ST_BUSY ##1 st_q == biss_slave_pkg::ST_DATA
      |-> $past(busy_cnt_q) >= BUSY_C + {period_q, 1'b0})
      else $error("start bit sent before busy time elapsed");
   frame_len_a: assert property (
      st_q == biss_slave_pkg::ST_DATA ##1 st_q == biss_slave_pkg::ST_TOUT
      |-> $past(bcnt_q) == FB_C)
      else $error("frame length wrong");
   tout_min_a: assert property (
      st_q != biss_slave_pkg::ST_IDLE && st_q != biss_slave_pkg::ST_BUSY
      ##1 st_q == biss_slave_pkg::ST_IDLE
      |-> $past(per_cnt_q) >= $past(period_q) + ($past(period_q) >> 1))
      else $error("timeout taken too early");
   tout_idle_a: assert property (
      st_q == biss_slave_pkg::ST_TOUT && tout_hit
      |=> st_q == biss_slave_pkg::ST_IDLE && SLO)
      else $error("line not idle after timeout");
   crc_field_a: assert property (request_s |=> shift_q[5:0] ==
      ~biss_slave_pkg::crc6(shift_q[FB-3:6]))
      else $error("crc field not inverted crc of data");
   err_bit_a: assert property (request_s |=> shift_q[7] ==
      !$past(|ERR_STATUS))
      else $error("error bit does not reflect error status");
   warn_bit_a: assert property (request_s |=> shift_q[6] ==
      !$past(|WARN_STATUS))
      else $error("warning bit does not reflect warning status");
   clear_once_a: assert property (
      |CLEAR_PULSE |-> $onehot(CLEAR_PULSE) ##1 CLEAR_PULSE == '0)
      else $error("clear pulse not single one-cycle");
   fresh_pop_a: assert property (
      request_s ##0 fifo_valid |=> pos_q == $past(fifo_data))
      else $error("fresh sample not latched on request");
endmodule
`default_nettype wire

// ---- hdl/biss_slave_pkg.sv ----
// constants and types shared by the position link slave
//
// Function
// - position word is 23 single-turn bits plus 16 multi-turn bits, 39 total
// - multi-turn count from the energy-harvested counter passes through untouched
// - data line held busy at least two periods plus 3.35 us before start
// - end of transfer seen after 1.5 idle periods, then line returns idle
// - six-bit CRC on x^6+x+1, sent inverted
// - frame error bit is low whenever any error source is active
// - frame warning bit is low whenever any warning source is active
// - clear command is a one-bit write, acts once, one command at a time
package biss_slave_pkg;
   localparam int ST_W       = 23;
   localparam int MT_W       = 16;
   localparam int POS_W      = ST_W + MT_W;
   localparam int CRC_W      = 6;
   localparam logic [CRC_W-1:0] CRC_POLY = 6'h03;
   localparam int DATA_W     = POS_W + 2;
   localparam int FRAME_BITS = DATA_W + CRC_W + 2;
   localparam int BCNT_W     = 6;
   localparam int ERR_N      = 5;
   localparam int WARN_N     = 2;
   localparam int CLR_N      = 4;
   localparam int CLR_MT     = 0;
   localparam int CLR_ST     = 1;
   localparam int CLR_ERR    = 2;
   localparam int CLR_WARN   = 3;
   localparam int CNT_W      = 10;
   localparam logic [CNT_W-1:0] CNT_MAX = 10'h3FF;
   localparam int CLK_HZ     = 10_000_000;
   localparam int CLK_NS     = 100;
   localparam int BUSY_NS    = 3350;
   localparam int BUSY_CYC   = (BUSY_NS + CLK_NS - 1) / CLK_NS;
   localparam int BUSY_EDGES = 2;
   localparam int INIT_MS    = 500;
   localparam int INIT_CYC   = INIT_MS * (CLK_HZ / 1000);
   localparam int FIFO_DEPTH = 2;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_BUSY = 4'h2,
      ST_DATA = 4'h4,
      ST_TOUT = 4'h8
   } link_state_t;

   // crc over data word, msb first, zero seed
   function automatic logic [CRC_W-1:0] crc6(input logic [DATA_W-1:0] d);
      logic [CRC_W-1:0] c;
      logic             fb;
      c = '0;
      for (int i = DATA_W - 1; i >= 0; i--)
      begin
         fb = c[CRC_W-1] ^ d[i];
         c  = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
      end
      return c;
   endfunction
endpackage

// ---- hdl/sample_buffer.sv ----
// two-entry valid/ready buffer for position samples
`timescale 1ns/1ps
`default_nettype none
module sample_buffer #(
   parameter int WIDTH = 39,
   parameter int DEPTH = 2
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output var  logic             out_valid,
   input  wire logic             out_ready,
   output var  logic [WIDTH-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_q;
   logic [PW-1:0]    rd_q;
   logic [CW-1:0]    cnt_q;
   logic [CW-1:0]    cnt_d;
   logic             push;
   logic             pop;

   // take a word only on a real handshake, never while ready is still low
   assign push      = in_valid && in_ready && (cnt_q != FULL_CNT);
   assign pop       = out_ready && (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign cnt_d     = cnt_q + CW'(push) - CW'(pop);

   always_ff @(posedge clk)
   begin
      if (push)
         mem_q[wr_q] <= in_data;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         if (push)
            wr_q <= (wr_q == LAST_PTR) ? '0 : wr_q + 1'b1;
         if (pop)
            rd_q <= (rd_q == LAST_PTR) ? '0 : rd_q + 1'b1;
      end
   end

   // flags kept in flops so both handshake outputs are registered
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q     <= '0;
         in_ready  <= 1'b0;
         out_valid <= 1'b0;
      end
      else
      begin
         cnt_q     <= cnt_d;
         in_ready  <= (cnt_d != FULL_CNT);
         out_valid <= (cnt_d != '0);
      end
   end
endmodule
`default_nettype wire

// ---- sim/biss_master_model.sv ----
// behavioural link master: requests a frame, clocks it in, times it
`timescale 1ns/1ps
`default_nettype none
module biss_master_model #(
   parameter int HALF_NS = 400
) (
   output var  logic ma,
   input  wire logic slo
);
   initial ma = 1'b1;

   // clock stands high between frames, equal low and high phases
   task automatic frame(output logic [47:0] b, output int busy,
                        output int tout);
      realtime t0;
      realtime tr;
      bit      low;
      int      n;
      b = '0;
      busy = 0;
      tout = 0;
      low = 0;
      #37;
      t0 = $realtime;
      tr = t0;
      ma = 1'b0;
      // clock until the start bit follows the low busy phase
      for (n = 0; n < 40; n++)
      begin
         #(HALF_NS);
         if (low && slo === 1'b1)
         begin
            busy = int'(tr - t0);
            break;
         end
         low = low | (slo === 1'b0);
         ma = 1'b1;
         tr = $realtime;
         #(HALF_NS);
         ma = 1'b0;
      end
      // each bit is read just before the rise that replaces it
      for (int i = 47; i >= 0; i--)
      begin
         ma = 1'b1;
         #(HALF_NS);
         ma = 1'b0;
         #(HALF_NS);
         b[i] = slo;
      end
      ma = 1'b1;
      tr = $realtime;
      #(HALF_NS + 200);
      if (slo === 1'b0)
      begin
         for (n = 0; n < 100 && slo !== 1'b1; n++)
            #20;
         tout = int'($realtime - tr);
      end
      #(4 * HALF_NS);
   endtask
endmodule
`default_nettype wire

// ---- sim/tb_biss_position_slave.sv ----
// self-checking bench for the position link slave
`timescale 1ns/1ps
`default_nettype none
module tb_biss_position_slave;
   logic                              clk_sys = 1'b0;
   logic                              resetn = 1'b0;
   logic                              ma;
   logic                              slo;
   logic                              pos_valid = 1'b0;
   logic                              pos_ready;
   logic [biss_slave_pkg::ST_W-1:0]   pos_st = '0;
   logic [biss_slave_pkg::MT_W-1:0]   pos_mt = '0;
   logic [biss_slave_pkg::ERR_N-1:0]  err_src = '0;
   logic [biss_slave_pkg::WARN_N-1:0] warn_src = '0;
   logic [biss_slave_pkg::CLR_N-1:0]  clear_cmd = '0;
   logic [biss_slave_pkg::CLR_N-1:0]  clear_pulse;
   logic [biss_slave_pkg::ERR_N-1:0]  err_status;
   logic [biss_slave_pkg::WARN_N-1:0] warn_status;
   logic                              init_done;
   int                                bad_count = 0;
   int                                samples_checked = 0;

   always #50 clk_sys = ~clk_sys;

   biss_position_slave #(.INIT_CYC(20)) dut (
      .CLK_SYS(clk_sys), .RESETN(resetn), .MA(ma), .SLO(slo),
      .POS_VALID(pos_valid), .POS_READY(pos_ready), .POS_ST(pos_st),
      .POS_MT(pos_mt), .ERR_SRC(err_src), .WARN_SRC(warn_src),
      .CLEAR_CMD(clear_cmd), .CLEAR_PULSE(clear_pulse),
      .ERR_STATUS(err_status), .WARN_STATUS(warn_status),
      .INIT_DONE(init_done)
   );
   biss_master_model m (.ma(ma), .slo(slo));

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input int got, input int lo, input int hi);
      samples_checked++;
      if (got < lo || got > hi)
      begin
         bad_count++;
         $display("unexpected at %0t: got %0h want %0h..%0h", $time,
                  got, lo, hi);
      end
   endtask

   // cds, data word and inverted crc, msb first
   function automatic logic [47:0] frame_of(input logic [15:0] mt,
      input logic [22:0] st, input logic ne, input logic nw);
      logic [40:0] d;
      logic [5:0]  c;
      d = {mt, st, ne, nw};
      c = 6'h00;
      for (int i = 40; i >= 0; i--)
         c = {c[4:0], 1'b0} ^ ((c[5] ^ d[i]) ? 6'h03 : 6'h00);
      return {1'b0, d, ~c};
   endfunction

   task automatic tick();
      @(posedge clk_sys);
      #1;
   endtask

   task automatic read(input logic [47:0] exp);
      logic [47:0] f;
      int          busy;
      int          tout;
      m.frame(f, busy, tout);
      chk(f, exp);
      chk_rng(busy, 4950, 5750);
      chk_rng(tout, 1200, 1800);
   endtask

   task automatic push(input logic [15:0] mt, input logic [22:0] st);
      tick();
      pos_valid = 1'b1;
      pos_mt = mt;
      pos_st = st;
      for (int n = 0; n < 100 && pos_ready !== 1'b1; n++)
         tick();
      tick();
      pos_valid = 1'b0;
   endtask

   task automatic pulse(input logic [3:0] cmd, input logic [3:0] exp);
      tick();
      clear_cmd = cmd;
      tick();
      chk({44'h0, clear_pulse}, {44'h0, exp});
      clear_cmd = 4'h0;
      tick();
      chk({44'h0, clear_pulse}, 48'h0);
   endtask

   task automatic t_init();
      chk({46'h0, init_done, slo}, 48'h1);
      repeat (22) tick();
      chk({46'h0, init_done, pos_ready}, 48'h3);
      $display("test init done");
   endtask

   task automatic t_clear();
      for (int i = 0; i < 4; i++)
         pulse(4'h1 << i, 4'h1 << i);
      pulse(4'h3, 4'h0);
      err_src = 5'h04;
      tick();
      err_src = 5'h00;
      tick();
      chk({43'h0, err_status}, 48'h4);
      pulse(4'h4, 4'h4);
      chk({43'h0, err_status}, 48'h0);
      $display("test clear done");
   endtask

   task automatic t_stream();
      push(16'hA5C3, 23'h4B2D1E);
      push(16'hFFFF, 23'h000001);
      tick();
      chk({47'h0, pos_ready}, 48'h0);
      read(frame_of(16'hA5C3, 23'h4B2D1E, 1'b1, 1'b1));
      read(frame_of(16'hFFFF, 23'h000001, 1'b1, 1'b1));
      read(frame_of(16'hFFFF, 23'h000001, 1'b1, 1'b1));
      $display("test stream done");
   endtask

   task automatic t_status();
      tick();
      err_src = 5'h10;
      warn_src = 2'h2;
      tick();
      err_src = 5'h00;
      warn_src = 2'h0;
      read(frame_of(16'hFFFF, 23'h000001, 1'b0, 1'b0));
      pulse(4'h4, 4'h4);
      read(frame_of(16'hFFFF, 23'h000001, 1'b1, 1'b0));
      pulse(4'h8, 4'h8);
      chk({46'h0, warn_status}, 48'h0);
      $display("test status done");
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      #2_000_000;
      bad_count++;
      give_verdict();
   end

   initial
   begin
      repeat (10) @(posedge clk_sys);
      #1;
      resetn = 1'b1;
      t_init();
      t_clear();
      t_stream();
      t_status();
      give_verdict();
   end
endmodule
`default_nettype wire
